// ===== hdl/ctp_defines.svh
// Purpose: constants for the cascadable timer pair
// Assumes: 32-bit AXI4-Lite register bus, word aligned
// Notes: offsets are byte addresses
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CTP_OFF_LOW_CTRL 6'h00
`define CTP_OFF_HIGH_CTRL 6'h04
`define CTP_OFF_LOW_COUNT 6'h08
`define CTP_OFF_HIGH_COUNT 6'h0C
`define CTP_OFF_LOW_PERIOD 6'h10
`define CTP_OFF_HIGH_PERIOD 6'h14
// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define CTP_BIT_RUN 15
`define CTP_BIT_IDLE 13
`define CTP_BIT_GATE 6
`define CTP_BIT_PS_HI 5
`define CTP_BIT_PS_LO 4
`define CTP_BIT_JOIN 3
`define CTP_BIT_CS 1
// ----------------------------------------------------------------------
// write masks, reset values and prescaler limits
// ----------------------------------------------------------------------
`define CTP_LOW_MASK 16'hA07A
`define CTP_HIGH_MASK 16'hA072
`define CTP_CTRL_RST 16'h0000
`define CTP_PERIOD_RST 16'hFFFF
`define CTP_PS_DIV8 8'h07
`define CTP_PS_DIV64 8'h3F
`define CTP_PS_DIV256 8'hFF
`endif

// ===== hdl/ctp_pkg.sv
// Purpose: types for the cascadable timer pair
// Assumes: nothing
// Notes: none
package ctp_pkg;
   typedef enum logic [1:0] {
      CTP_PS_1, CTP_PS_8, CTP_PS_64, CTP_PS_256
   } ctp_prescale_t;
endpackage : ctp_pkg

// ===== hdl/ctp_timer_pair.sv
// Purpose: pair of 16-bit timers, joinable into one 32-bit timer
// Assumes: AXI4-Lite slave, one access of each kind at a time
// Notes: external clock and gate pins are synchronised on entry
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "ctp_defines.svh"
module ctp_timer_pair
   import ctp_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // device state and pins
   input wire logic i_idle,
   input wire logic i_low_ext_clock_pin,
   input wire logic i_high_ext_clock_pin,
   input wire logic i_low_gate,
   input wire logic i_high_gate,
   // axi4-lite write address
   input wire logic [5:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   // axi4-lite write data
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   // axi4-lite write response
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // axi4-lite read address
   input wire logic [5:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   // axi4-lite read data
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // timer events
   output logic o_low_flag,
   output logic o_high_flag
);
   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   logic [15:0] ctrl_q [2];
   logic [15:0] count_q [2];
   logic [15:0] period_q [2];
   logic [7:0] ps_q [2];
   logic [1:0] gate_prev_q;
   logic [1:0] ext_prev_q;
   logic half_q;
   logic [1:0] low_sync_q, high_sync_q, lg_sync_q, hg_sync_q;
   logic [1:0] flag_q;
   // bus state
   logic aw_held_q, w_held_q;
   logic [5:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   logic [1:0] ctrl_wr;
   logic [1:0] count_wr;
   logic [1:0] period_wr;
   logic [15:0] wr_val;
   logic joined;
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         low_sync_q <= 2'h0;
         high_sync_q <= 2'h0;
         lg_sync_q <= 2'h0;
         hg_sync_q <= 2'h0;
      end else begin
         low_sync_q <= {low_sync_q[0], i_low_ext_clock_pin};
         high_sync_q <= {high_sync_q[0], i_high_ext_clock_pin};
         lg_sync_q <= {lg_sync_q[0], i_low_gate};
         hg_sync_q <= {hg_sync_q[0], i_high_gate};
      end
   end
   // internal clock runs at half the system rate
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end
   // ----------------------------------------------------------------------
   // axi4-lite write side
   // ----------------------------------------------------------------------
   assign o_awready = !aw_held_q && !o_bvalid;
   assign o_wready = !w_held_q && !o_bvalid;
   assign do_write = aw_held_q && w_held_q;
   assign o_bresp = 2'h0;
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 6'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         o_bvalid <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            o_bvalid <= 1'b1;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end
   // byte lanes merged into the addressed 16-bit register
   always_comb begin
      logic [15:0] cur;
      cur = 16'h0000;
      unique case (awaddr_q)
         `CTP_OFF_LOW_CTRL: cur = ctrl_q[0];
         `CTP_OFF_HIGH_CTRL: cur = ctrl_q[1];
         `CTP_OFF_LOW_COUNT: cur = count_q[0];
         `CTP_OFF_HIGH_COUNT: cur = count_q[1];
         `CTP_OFF_LOW_PERIOD: cur = period_q[0];
         `CTP_OFF_HIGH_PERIOD: cur = period_q[1];
         default: cur = 16'h0000;
      endcase
      wr_val[7:0] = wstrb_q[0] ? wdata_q[7:0] : cur[7:0];
      wr_val[15:8] = wstrb_q[1] ? wdata_q[15:8] : cur[15:8];
   end
   assign ctrl_wr[0] = do_write && awaddr_q == `CTP_OFF_LOW_CTRL;
   assign ctrl_wr[1] = do_write && awaddr_q == `CTP_OFF_HIGH_CTRL;
   assign count_wr[0] = do_write && awaddr_q == `CTP_OFF_LOW_COUNT;
   assign count_wr[1] = do_write && awaddr_q == `CTP_OFF_HIGH_COUNT;
   assign period_wr[0] = do_write && awaddr_q == `CTP_OFF_LOW_PERIOD;
   assign period_wr[1] = do_write && awaddr_q == `CTP_OFF_HIGH_PERIOD;
   // ----------------------------------------------------------------------
   // control and period registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ctrl_q[0] <= `CTP_CTRL_RST;
         ctrl_q[1] <= `CTP_CTRL_RST;
         period_q[0] <= `CTP_PERIOD_RST;
         period_q[1] <= `CTP_PERIOD_RST;
      end else begin
         if (ctrl_wr[0]) ctrl_q[0] <= wr_val & `CTP_LOW_MASK;
         if (ctrl_wr[1]) ctrl_q[1] <= wr_val & `CTP_HIGH_MASK;
         if (period_wr[0]) period_q[0] <= wr_val;
         if (period_wr[1]) period_q[1] <= wr_val;
      end
   end
   assign joined = ctrl_q[0][`CTP_BIT_JOIN];
   // ----------------------------------------------------------------------
   // per timer tick generation and counting
   // ----------------------------------------------------------------------
   logic [1:0] tick;
   logic [1:0] gate_fall;
   logic [1:0] match;
   logic [1:0] ext_lvl;
   logic [1:0] gate_lvl;
   logic carry_match;
   assign ext_lvl = {high_sync_q[1], low_sync_q[1]};
   assign gate_lvl = {hg_sync_q[1], lg_sync_q[1]};
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_tmr
         logic [15:0] cs; // effective control
         logic run, src_ext, gated, edge_in, ps_done;
         logic [7:0] ps_lim;
         ctp_prescale_t ps_sel;
         // joined pair follows the low control only
         assign cs = joined ? ctrl_q[0] : ctrl_q[g];
         assign run = cs[`CTP_BIT_RUN]
            && !(cs[`CTP_BIT_IDLE] && i_idle);
         assign src_ext = cs[`CTP_BIT_CS];
         assign gated = cs[`CTP_BIT_GATE] && !src_ext;
         assign ps_sel = ctp_prescale_t'(cs[`CTP_BIT_PS_HI:`CTP_BIT_PS_LO]);
         always_comb begin
            unique case (ps_sel)
               CTP_PS_1: ps_lim = 8'h00;
               CTP_PS_8: ps_lim = `CTP_PS_DIV8;
               CTP_PS_64: ps_lim = `CTP_PS_DIV64;
               CTP_PS_256: ps_lim = `CTP_PS_DIV256;
            endcase
         end
         // joined: both halves use the low timer's pin and gate
         assign edge_in = src_ext
            ? ((joined ? ext_lvl[0] : ext_lvl[g])
               && !(joined ? ext_prev_q[0] : ext_prev_q[g]))
            : (half_q && (!gated || (joined ? gate_lvl[0] : gate_lvl[g])));
         assign ps_done = edge_in && ps_q[g] == ps_lim;
         assign tick[g] = run && ps_done;
         assign gate_fall[g] = run && gated
            && !(joined ? gate_lvl[0] : gate_lvl[g])
            && (joined ? gate_prev_q[0] : gate_prev_q[g]);
         assign match[g] = count_q[g] == period_q[g];
         always_ff @(posedge i_clk) begin
            if (!i_rstn) begin
               ps_q[g] <= 8'h00;
            end else if ((ctrl_wr[g] || (g == 1 && joined && ctrl_wr[0]))
               && cs[`CTP_BIT_RUN]) begin
               ps_q[g] <= 8'h00;
            end else if (run && edge_in) begin
               ps_q[g] <= ps_done ? 8'h00 : ps_q[g] + 8'h01;
            end
         end
      end
   endgenerate
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ext_prev_q <= 2'h0;
         gate_prev_q <= 2'h0;
      end else begin
         ext_prev_q <= ext_lvl;
         gate_prev_q <= gate_lvl;
      end
   end
   assign carry_match = match[0] && match[1];
   // ----------------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         count_q[0] <= 16'h0000;
         count_q[1] <= 16'h0000;
      end else begin
         if (joined) begin
            // low tick drives the full 32-bit word
            if (tick[0]) begin
               if (carry_match) begin
                  count_q[0] <= 16'h0000;
                  count_q[1] <= 16'h0000;
               end else begin
                  count_q[0] <= count_q[0] + 16'h0001;
                  if (count_q[0] == 16'hFFFF) begin
                     count_q[1] <= count_q[1] + 16'h0001;
                  end
               end
            end
         end else begin
            for (int i = 0; i < 2; i++) begin
               if (tick[i]) begin
                  count_q[i] <= match[i] ? 16'h0000
                     : count_q[i] + 16'h0001;
               end
            end
         end
         // software writes win over counting
         if (count_wr[0]) count_q[0] <= wr_val;
         if (count_wr[1]) count_q[1] <= wr_val;
      end
   end
   // ----------------------------------------------------------------------
   // event pulses
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         flag_q <= 2'h0;
      end else if (joined) begin
         flag_q[0] <= 1'b0;
         flag_q[1] <= (tick[0] && carry_match) || gate_fall[0];
      end else begin
         flag_q[0] <= (tick[0] && match[0]) || gate_fall[0];
         flag_q[1] <= (tick[1] && match[1]) || gate_fall[1];
      end
   end
   assign o_low_flag = flag_q[0];
   assign o_high_flag = flag_q[1];
   // ----------------------------------------------------------------------
   // axi4-lite read side
   // ----------------------------------------------------------------------
   assign o_arready = !o_rvalid;
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= 2'h0;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rresp <= 2'h0;
         unique case (i_araddr)
            `CTP_OFF_LOW_CTRL: o_rdata <= {16'h0000, ctrl_q[0]};
            `CTP_OFF_HIGH_CTRL: o_rdata <= {16'h0000, ctrl_q[1]};
            `CTP_OFF_LOW_COUNT: o_rdata <= {16'h0000, count_q[0]};
            `CTP_OFF_HIGH_COUNT: o_rdata <= {16'h0000, count_q[1]};
            `CTP_OFF_LOW_PERIOD: o_rdata <= {16'h0000, period_q[0]};
            `CTP_OFF_HIGH_PERIOD: o_rdata <= {16'h0000, period_q[1]};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule : ctp_timer_pair

// ===== tb/ctp_timer_pair_checker.sv
// Purpose: port-level assertions for the timer pair
// Assumes: single clock, synchronous active-low reset
// Notes: bound to every instance of the top module
`timescale 1ns/100ps
module ctp_timer_pair_checker (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // bus handshakes
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // events
   input wire logic o_low_flag,
   input wire logic o_high_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   bresp_okay_a: assert property (o_bvalid |-> o_bresp == 2'b00)
      else $error("write response not okay");
   rresp_okay_a: assert property (o_rvalid |-> o_rresp == 2'b00)
      else $error("read response not okay");
   rdata_hold_a: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read data dropped");
   bvalid_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   ar_block_a: assert property (o_rvalid |-> !o_arready)
      else $error("read address taken while answering");
   write_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while answering");
   bresp_after_a: assert property ($rose(o_bvalid) |->
      $past(o_awready) == 1'b0) else $error("response before write");
   flag_pulse_a: assert property (o_low_flag |=> !o_low_flag)
      else $error("low flag longer than one cycle");
   reset_clear_a: assert property (disable iff (1'b0) !i_rstn |=>
      !o_low_flag && !o_high_flag && !o_bvalid && !o_rvalid)
      else $error("outputs not cleared by reset");
   cover property (o_low_flag);
   cover property (o_high_flag);
   cover property (o_bvalid && i_bready);
   cover property (o_rvalid && i_rready);
endmodule : ctp_timer_pair_checker
bind ctp_timer_pair ctp_timer_pair_checker u_chk (.*);

// ===== tb/ctp_timer_pair_tb.sv
// Purpose: self-checking bench for the timer pair
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes: prescaled gaps measured between flag pulses
`timescale 1ns/100ps
`include "ctp_defines.svh"
module ctp_timer_pair_tb;
   import ctp_pkg::*;
   localparam logic [5:0] LC = `CTP_OFF_LOW_CTRL, HC = `CTP_OFF_HIGH_CTRL;
   localparam logic [5:0] LN = `CTP_OFF_LOW_COUNT, HN = `CTP_OFF_HIGH_COUNT;
   localparam logic [5:0] LP = `CTP_OFF_LOW_PERIOD, HP = `CTP_OFF_HIGH_PERIOD;
   logic i_clk = 0, i_rstn = 0, i_idle = 0, lpin = 0, hpin = 0, lgate = 0;
   logic [5:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, o_rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic o_low_flag, o_high_flag;
   logic [1:0] o_bresp, o_rresp;
   logic [31:0] rv;
   int n_mismatch = 0, checked = 0, n;
   bit lseen;
   always #5 i_clk = ~i_clk;
   ctp_timer_pair dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_idle(i_idle),
      .i_low_ext_clock_pin(lpin), .i_high_ext_clock_pin(hpin),
      .i_low_gate(lgate), .i_high_gate(1'b0), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
      .i_wstrb(4'h3), .i_wvalid(wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
      .i_rready(rready), .o_low_flag(o_low_flag), .o_high_flag(o_high_flag));
   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      bit aw = 0, w = 0;
      @(posedge i_clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge i_clk);
         if (awvalid && o_awready) begin aw = 1; awvalid <= 1'b0; end
         if (wvalid && o_wready) begin w = 1; wvalid <= 1'b0; end
      end while (!(aw && w));
      while (!o_bvalid) @(posedge i_clk);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a);
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge i_clk); while (!o_arready);
      arvalid <= 1'b0;
      while (!o_rvalid) @(posedge i_clk);
      rv = o_rdata;
      rready <= 1'b0;
   endtask : rd
   task automatic rchk(input logic [5:0] a, input logic [31:0] e);
      rd(a);
      checked++;
      if (rv !== e) begin
         n_mismatch++;
         $display("[FAIL] reg %h exp %h got %h", a, e, rv);
      end
   endtask : rchk
   task automatic chk(input string s, input logic e);
      checked++;
      if (e !== 1'b1) begin
         n_mismatch++;
         $display("[FAIL] %s exp 1 got %b", s, e);
      end
   endtask : chk
   // cycles between two successive pulses of one flag
   task automatic gap(input bit hi, output int c);
      c = 0;
      do @(posedge i_clk); while (!(hi ? o_high_flag : o_low_flag));
      do begin @(posedge i_clk); c++; end
      while (!(hi ? o_high_flag : o_low_flag));
   endtask : gap
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (60000) @(posedge i_clk);
      n_mismatch++;
      tally_and_finish;
   end
   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge i_clk);
      i_rstn <= 1'b1;
      rchk(LC, 0);
      rchk(HC, 0);
      rchk(LN, 0);
      rchk(LP, 32'h0000_FFFF);
      wr(6'h18, 16'h1234);
      rchk(6'h18, 0);
      wr(LC, 16'h7FFF);
      rchk(LC, 32'h0000_207A);
      wr(HC, 16'h7FFF);
      rchk(HC, 32'h0000_2072);
      wr(LC, 16'h5F85);
      rchk(LC, 0);
      wr(HC, 0);
      // unjoined low timer through every prescale setting
      wr(LP, 16'h0003);
      for (int p = 0; p < 4; p++) begin
         wr(LC, 16'h8000 | 16'(p << 4));
         gap(1'b0, n);
         chk("low gap", n == 8 * (1 << (3 * p - (p == 3 ? 1 : 0))));
      end
      // rewrites every ~100 cycles keep the 1:256 prescaler from finishing
      wr(LC, 16'h8030);
      wr(LN, 0);
      repeat (6) begin
         repeat (100) @(posedge i_clk);
         wr(LC, 16'h8030);
      end
      rchk(LN, 0);
      rchk(HN, 0);
      wr(LC, 0);
      wr(LP, 16'hFFFF);
      wr(LN, 0);
      wr(HN, 0);
      wr(LC, 16'h8042);
      wr(HC, 16'h8042);
      repeat (5) begin
         @(posedge i_clk) {lpin, hpin} <= 2'b11;
         repeat (4) @(posedge i_clk);
         {lpin, hpin} <= 2'b00;
         repeat (4) @(posedge i_clk);
      end
      repeat (8) @(posedge i_clk);
      rchk(LN, 5);
      rchk(HN, 5);
      wr(HC, 0);
      i_idle <= 1'b1;
      wr(LP, 16'hFFFF);
      wr(LC, 0);
      wr(LN, 0);
      wr(LC, 16'hA000);
      repeat (20) @(posedge i_clk);
      rchk(LN, 0);
      wr(LC, 16'h8000);
      repeat (20) @(posedge i_clk);
      rd(LN);
      chk("idle run", rv != 0);
      i_idle <= 1'b0;
      // gated accumulation on the low timer
      wr(LC, 0);
      wr(LN, 0);
      wr(LC, 16'h8040);
      repeat (10) @(posedge i_clk);
      rchk(LN, 0);
      lgate <= 1'b1;
      repeat (20) @(posedge i_clk);
      lgate <= 1'b0;
      n = 0;
      while (!o_low_flag && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      chk("gate fall flag", n < 20);
      rd(LN);
      chk("gated count", rv != 0);
      // joined pair: 32-bit match at 0x0001_0001 from 0x0000_FFFE
      wr(LC, 16'h0008);
      wr(HC, 16'h8032);
      wr(LP, 16'h0001);
      wr(HP, 16'h0001);
      wr(LN, 16'hFFFE);
      wr(HN, 0);
      wr(LC, 16'h8008);
      n = 0;
      lseen = 0;
      while (!o_high_flag && n < 60) begin
         @(posedge i_clk);
         lseen |= o_low_flag;
         n++;
      end
      chk("joined match", n < 60);
      chk("low flag quiet", !lseen);
      wr(LC, 16'h0008);
      rchk(HN, 0);
      tally_and_finish;
   end
endmodule : ctp_timer_pair_tb
